// ---- qmc_pkg.sv ----
// Constants, states and carriers for the quad mode entry/exit control block.
// Assumes a host SPI controller in mode 0 and an APB master on mclk.
package qmc_pkg;

  // Serial instructions
  localparam logic [7:0] CMD_RD_SR1   = 8'h05;
  localparam logic [7:0] CMD_RD_SR2   = 8'h35;
  localparam logic [7:0] CMD_WR_SR    = 8'h01;
  localparam logic [7:0] CMD_QUAD_ON  = 8'h38;
  localparam logic [7:0] CMD_QUAD_OFF = 8'hF5;
  localparam logic [7:0] CMD_RD_DISC  = 8'h5A;
  localparam logic [7:0] CMD_RD_QIO   = 8'hEB;

  // Continuous read mode byte
  localparam logic [3:0] MODE_KEEP_NIB = 4'hA;
  localparam logic [3:0] MODE_RST_NIB  = 4'hF;
  localparam logic [3:0] MODE_RST_CLKS = 4'd8;

  // Status bit positions
  localparam int SR1_BUSY_BIT = 0;
  localparam int SR2_QLE_BIT  = 1;

  // Phase lengths in link clocks
  localparam logic [5:0] CLK_CMD_1L   = 6'd8;
  localparam logic [5:0] CLK_CMD_4L   = 6'd2;
  localparam logic [5:0] CLK_ADDR_1L  = 6'd24;
  localparam logic [5:0] CLK_ADDR_4L  = 6'd6;
  localparam logic [5:0] CLK_MODE     = 6'd2;
  localparam logic [5:0] CLK_DUM_QIO  = 6'd4;
  localparam logic [5:0] CLK_DUM_DISC = 6'd8;
  localparam logic [5:0] CLK_WSR_1L   = 6'd16;
  localparam logic [5:0] CLK_WSR_4L   = 6'd4;

  // Discoverable-parameter dword at relative bytes 38h..3Bh
  localparam logic [7:0] DISC_BASE = 8'h38;
  localparam logic [7:0] DISC_B0   = 8'h22;
  localparam logic [7:0] DISC_B1   = 8'hF6;
  localparam logic [7:0] DISC_B2   = 8'h5D;
  localparam logic [7:0] DISC_B3   = 8'hFF;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  // APB map
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic        CTRL_RST   = 1'b0;

  typedef enum {ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_TX, ST_WSR, ST_IDLE} qmc_state_e;
  typedef enum {OP_SR1, OP_SR2, OP_DISC, OP_QIO} qmc_op_e;

  typedef struct packed {
    logic four_lane_command_mode;
    logic cont_read;
    logic quad_lane_enable_bit;
  } qmc_stat_s;

endpackage

// ---- qmc_ctrl.sv ----
// Quad mode entry/exit control: SPI command interpreter on the link clock,
// APB control/status registers on mclk, level crossings between them.
// Assumes SPI mode 0; sclk may stop while cs_n is high.
//
// Overview of operation
// - Discoverable table bytes 38h..3Bh read back as 22h, F6h, 5Dh, FFh.
// - Quad-enable lives in bit 1 of the second status register.
// - Instruction 05h returns the first status register.
// - Instruction 35h returns the second status register with quad-enable.
// - Write-status 01h with second byte bit 1 set sets quad-enable.
// - Write-status 01h with second byte bit 1 clear clears quad-enable.
// - Mode byte A5h after the address enters continuous read mode.
// - Any mode byte with upper nibble A enters or keeps continuous mode.
// - Mode byte 00h leaves continuous mode after the current read.
// - Eight clocks of Fh on the data lines leave continuous mode.
// - Instruction 38h enters four-lane command mode.
// - Instruction F5h in four-lane form returns to single-lane commands.
// - Hold and write-protect disable is unsupported and reported so.
// - Busy shows in bit 0 of the first status register.
//
// Design decisions made here: register access over APB and the address map.
module qmc_ctrl (
  input  wire logic        mclk,     // System clock
  input  wire logic        rst,      // Async reset, active high
  input  wire logic        ce,       // Clock enable for mclk state
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [11:0] paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic             pready,   // APB ready
  output logic      [31:0] prdata,   // APB read data
  output logic             pslverr,  // APB error
  input  wire logic        sclk,     // Link clock
  input  wire logic        cs_n,     // Chip select, active low
  input  wire logic [3:0]  quad_data_lines_i,   // Data lines in
  output logic      [3:0]  quad_data_lines_o,   // Data lines out
  output logic      [3:0]  quad_data_lines_oe_n // Output enable, low drives
);

  // ---------------- Link domain ----------------
  logic frame_rst;
  assign frame_rst = rst | cs_n;

  qmc_pkg::qmc_state_e st_q, st_d;
  qmc_pkg::qmc_op_e    op_q, op_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [23:0] sh_q, sh_d;
  logic [7:0]  addr_q, addr_d;
  logic [7:0]  tx_q, tx_d;
  logic [2:0]  bitc_q, bitc_d;
  logic        txon_q, txon_d;
  logic        first_q, first_d;
  logic [3:0]  ffc_q, ffc_d;
  logic        fflive_q, fflive_d;
  logic        qle_q, qle_d;
  logic        cont_q, cont_d;
  logic        fourl_q, fourl_d;
  logic        busy_m1_q, busy_m2_q;
  logic [3:0]  dqo_q, dqo_d;
  logic [3:0]  oen_q, oen_d;
  logic        opipf_q;  // operation_in_progress_flag, mclk domain

  function automatic logic [7:0] byte_for(input qmc_pkg::qmc_op_e op,
                                          input logic [7:0] a,
                                          input logic busy,
                                          input logic qle);
    logic [7:0] b;
    b = qmc_pkg::FILL_BYTE;
    case (op)
      qmc_pkg::OP_SR1: begin
        b = 8'h00;
        b[qmc_pkg::SR1_BUSY_BIT] = busy;
      end
      qmc_pkg::OP_SR2: begin
        b = 8'h00;
        b[qmc_pkg::SR2_QLE_BIT] = qle;
      end
      qmc_pkg::OP_DISC: begin
        // Bit 23 of the dword stays 0: hold/WP disable unsupported
        case (a - qmc_pkg::DISC_BASE)
          8'h00:   b = qmc_pkg::DISC_B0;
          8'h01:   b = qmc_pkg::DISC_B1;
          8'h02:   b = qmc_pkg::DISC_B2;
          8'h03:   b = qmc_pkg::DISC_B3;
          default: b = qmc_pkg::FILL_BYTE;
        endcase
      end
      default: b = qmc_pkg::FILL_BYTE;  // No array behind this block
    endcase
    return b;
  endfunction

  always_comb begin
    qmc_pkg::qmc_state_e st_e;
    qmc_pkg::qmc_op_e    op_e;
    logic                wide;
    logic [5:0]          last;
    logic [7:0]          nb;
    st_e   = st_q;
    op_e   = op_q;
    wide   = 1'b0;
    last   = 6'd0;
    nb     = 8'h00;
    st_d   = st_q;
    op_d   = op_q;
    cnt_d  = cnt_q + 6'd1;
    addr_d = addr_q;
    tx_d   = tx_q;
    bitc_d = bitc_q;
    txon_d = txon_q;
    first_d = 1'b0;
    ffc_d  = ffc_q;
    fflive_d = fflive_q;
    qle_d  = qle_q;
    cont_d = cont_q;
    fourl_d = fourl_q;
    if (first_q && cont_q) begin
      // No instruction byte: the address phase owns the first clock
      st_e = qmc_pkg::ST_ADDR;
      op_e = qmc_pkg::OP_QIO;
      op_d = qmc_pkg::OP_QIO;
      st_d = qmc_pkg::ST_ADDR;
    end
    case (st_e)
      qmc_pkg::ST_CMD:  wide = fourl_q;
      qmc_pkg::ST_ADDR: wide = fourl_q || (op_e == qmc_pkg::OP_QIO);
      qmc_pkg::ST_MODE: wide = 1'b1;
      qmc_pkg::ST_WSR:  wide = fourl_q;
      default:          wide = 1'b0;
    endcase
    sh_d = wide ? {sh_q[19:0], quad_data_lines_i} : {sh_q[22:0], quad_data_lines_i[0]};
    case (st_e)
      qmc_pkg::ST_CMD: begin
        last = fourl_q ? qmc_pkg::CLK_CMD_4L - 6'd1 : qmc_pkg::CLK_CMD_1L - 6'd1;
        if (cnt_q == last) begin
          cnt_d = 6'd0;
          st_d  = qmc_pkg::ST_IDLE;
          case (sh_d[7:0])
            qmc_pkg::CMD_RD_SR1: begin
              op_d = qmc_pkg::OP_SR1;
              st_d = qmc_pkg::ST_TX;
              tx_d = byte_for(qmc_pkg::OP_SR1, addr_q, busy_m2_q, qle_q);
              bitc_d = 3'd0;
              txon_d = 1'b1;
            end
            qmc_pkg::CMD_RD_SR2: begin
              op_d = qmc_pkg::OP_SR2;
              st_d = qmc_pkg::ST_TX;
              tx_d = byte_for(qmc_pkg::OP_SR2, addr_q, busy_m2_q, qle_q);
              bitc_d = 3'd0;
              txon_d = 1'b1;
            end
            qmc_pkg::CMD_WR_SR:   st_d = qmc_pkg::ST_WSR;
            qmc_pkg::CMD_QUAD_ON: fourl_d = 1'b1;
            qmc_pkg::CMD_QUAD_OFF: begin
              if (fourl_q) begin
                fourl_d = 1'b0;
              end
            end
            qmc_pkg::CMD_RD_DISC: begin
              op_d = qmc_pkg::OP_DISC;
              st_d = qmc_pkg::ST_ADDR;
            end
            qmc_pkg::CMD_RD_QIO: begin
              // Quad read refused unless quad-enable or four-lane command mode is set
              if (qle_q || fourl_q) begin
                op_d = qmc_pkg::OP_QIO;
                st_d = qmc_pkg::ST_ADDR;
              end
            end
            default: st_d = qmc_pkg::ST_IDLE;
          endcase
        end
      end
      qmc_pkg::ST_ADDR: begin
        last = wide ? qmc_pkg::CLK_ADDR_4L - 6'd1 : qmc_pkg::CLK_ADDR_1L - 6'd1;
        if (cnt_q == last) begin
          cnt_d  = 6'd0;
          addr_d = sh_d[7:0];
          st_d   = (op_e == qmc_pkg::OP_QIO) ? qmc_pkg::ST_MODE : qmc_pkg::ST_DUMMY;
        end
      end
      qmc_pkg::ST_MODE: begin
        if (cnt_q == qmc_pkg::CLK_MODE - 6'd1) begin
          cnt_d = 6'd0;
          st_d  = qmc_pkg::ST_DUMMY;
          // Any other byte, 00h among them, drops the mode for the next frame
          cont_d = (sh_d[7:4] == qmc_pkg::MODE_KEEP_NIB);
        end
      end
      qmc_pkg::ST_DUMMY: begin
        last = (op_q == qmc_pkg::OP_QIO) ? qmc_pkg::CLK_DUM_QIO - 6'd1
                                         : qmc_pkg::CLK_DUM_DISC - 6'd1;
        if (cnt_q == last) begin
          cnt_d  = 6'd0;
          st_d   = qmc_pkg::ST_TX;
          tx_d   = byte_for(op_q, addr_q, busy_m2_q, qle_q);
          bitc_d = 3'd0;
          txon_d = 1'b1;
        end
      end
      qmc_pkg::ST_TX: begin
        cnt_d = 6'd0;
        wide = fourl_q || (op_q == qmc_pkg::OP_QIO);
        if (bitc_q == (wide ? 3'd1 : 3'd7)) begin
          nb = addr_q + 8'd1;
          if (op_q == qmc_pkg::OP_DISC || op_q == qmc_pkg::OP_QIO) begin
            addr_d = nb;
          end else begin
            nb = addr_q;
          end
          tx_d   = byte_for(op_q, nb, busy_m2_q, qle_q);
          bitc_d = 3'd0;
        end else begin
          tx_d   = wide ? {tx_q[3:0], 4'h0} : {tx_q[6:0], 1'b0};
          bitc_d = bitc_q + 3'd1;
        end
      end
      qmc_pkg::ST_WSR: begin
        last = fourl_q ? qmc_pkg::CLK_WSR_4L - 6'd1 : qmc_pkg::CLK_WSR_1L - 6'd1;
        if (cnt_q == last) begin
          cnt_d = 6'd0;
          st_d  = qmc_pkg::ST_IDLE;
          qle_d = sh_d[qmc_pkg::SR2_QLE_BIT];
        end
      end
      qmc_pkg::ST_IDLE: cnt_d = 6'd0;
      default: st_d = qmc_pkg::ST_IDLE;
    endcase
    // Mode reset: all ones on the lanes from the first clock of a frame
    // A frame that opens outside continuous mode must not arm it later
    if (fflive_q) begin
      if (cont_q && quad_data_lines_i == qmc_pkg::MODE_RST_NIB) begin
        ffc_d = ffc_q + 4'd1;
        if (ffc_q == qmc_pkg::MODE_RST_CLKS - 4'd1) begin
          cont_d   = 1'b0;
          fflive_d = 1'b0;
          st_d     = qmc_pkg::ST_IDLE;
          txon_d   = 1'b0;
        end
      end else begin
        fflive_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      st_q     <= qmc_pkg::ST_CMD;
      op_q     <= qmc_pkg::OP_SR1;
      cnt_q    <= 6'd0;
      sh_q     <= 24'h00_0000;
      addr_q   <= 8'h00;
      tx_q     <= 8'h00;
      bitc_q   <= 3'd0;
      txon_q   <= 1'b0;
      first_q  <= 1'b1;
      ffc_q    <= 4'd0;
      fflive_q <= 1'b1;
    end else begin
      st_q     <= st_d;
      op_q     <= op_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      addr_q   <= addr_d;
      tx_q     <= tx_d;
      bitc_q   <= bitc_d;
      txon_q   <= txon_d;
      first_q  <= first_d;
      ffc_q    <= ffc_d;
      fflive_q <= fflive_d;
    end
  end

  // Mode state survives chip-select framing
  // Busy sync moves only while sclk runs; the first frame clocks carry it
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      qle_q     <= 1'b0;
      cont_q    <= 1'b0;
      fourl_q   <= 1'b0;
      busy_m1_q <= 1'b0;
      busy_m2_q <= 1'b0;
    end else begin
      qle_q     <= qle_d;
      cont_q    <= cont_d;
      fourl_q   <= fourl_d;
      busy_m1_q <= opipf_q;
      busy_m2_q <= busy_m1_q;
    end
  end

  // Launch on the falling edge so the host samples on the next rising edge
  always_comb begin
    dqo_d = 4'h0;
    oen_d = 4'hF;
    if (txon_q) begin
      if (fourl_q || op_q == qmc_pkg::OP_QIO) begin
        dqo_d = tx_q[7:4];
        oen_d = 4'h0;
      end else begin
        dqo_d = {2'b00, tx_q[7], 1'b0};
        oen_d = 4'hD;
      end
    end
  end

  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      dqo_q <= 4'h0;
      oen_q <= 4'hF;
    end else begin
      dqo_q <= dqo_d;
      oen_q <= oen_d;
    end
  end

  assign quad_data_lines_o    = dqo_q;
  assign quad_data_lines_oe_n = oen_q;

  // ---------------- mclk domain ----------------
  qmc_pkg::qmc_stat_s stat_link, stat_m1_q, stat_m2_q;
  logic        opipf_d;
  logic        rdy_q, rdy_d;
  logic        err_q, err_d;
  logic [31:0] rd_q, rd_d;

  // Independent slow levels, so a per-bit two-flop sync is enough
  assign stat_link.four_lane_command_mode = fourl_q;
  assign stat_link.cont_read              = cont_q;
  assign stat_link.quad_lane_enable_bit   = qle_q;

  always_comb begin
    opipf_d = opipf_q;
    rdy_d   = 1'b0;
    err_d   = 1'b0;
    rd_d    = 32'h0000_0000;
    if (psel && !penable) begin
      rdy_d = 1'b1;
      case (paddr)
        qmc_pkg::OFS_CTRL:   rd_d = {31'h0000_0000, opipf_q};
        qmc_pkg::OFS_STATUS: rd_d = {29'h0000_0000, stat_m2_q};
        default:             err_d = 1'b1;
      endcase
    end
    // Write lands at the access edge only
    if (psel && penable && rdy_q && pwrite && paddr == qmc_pkg::OFS_CTRL) begin
      opipf_d = pwdata[0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      opipf_q   <= qmc_pkg::CTRL_RST;
      rdy_q     <= 1'b0;
      err_q     <= 1'b0;
      rd_q      <= 32'h0000_0000;
      stat_m1_q <= '0;
      stat_m2_q <= '0;
    end else if (ce) begin
      opipf_q   <= opipf_d;
      rdy_q     <= rdy_d;
      err_q     <= err_d;
      rd_q      <= rd_d;
      stat_m1_q <= stat_link;
      stat_m2_q <= stat_m1_q;
    end
  end

  assign pready  = rdy_q;
  assign pslverr = err_q;
  assign prdata  = rd_q;

endmodule // qmc_ctrl

// ---- qmc_ctrl_checker.sv ----
// Port assertions for the quad mode control block.
// Assumes binding to the top module ports; two clock domains.
module qmc_ctrl_checker (
  input wire logic        mclk,                // Clock
  input wire logic        rst,                 // Reset
  input wire logic        ce,                  // Enable
  input wire logic        psel,                // APB
  input wire logic        penable,             // APB
  input wire logic        pwrite,              // APB
  input wire logic [11:0] paddr,               // APB
  input wire logic        pready,              // APB
  input wire logic [31:0] prdata,              // APB
  input wire logic        pslverr,             // APB
  input wire logic        sclk,                // Link clock
  input wire logic        cs_n,                // Select
  input wire logic [3:0]  quad_data_lines_oe_n // Enables
);
  logic map_w;
  assign map_w = paddr == qmc_pkg::OFS_CTRL || paddr == qmc_pkg::OFS_STATUS;
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_answer;
    @(posedge mclk) disable iff (rst) s_setup |=> s_access;
  endproperty
  a_answer_next: assert property (p_answer) else $error("no ready after setup");
  a_ready_single: assert property (@(posedge mclk) disable iff (rst)
    pready && ce |=> !pready) else $error("ready held");
  a_ready_cause: assert property (@(posedge mclk) disable iff (rst)
    pready |-> $past(psel && !penable)) else $error("ready without setup");
  a_err_unmap: assert property (@(posedge mclk) disable iff (rst)
    pready && !map_w |-> pslverr && prdata == 32'h0000_0000) else $error("no error");
  a_err_mapped: assert property (@(posedge mclk) disable iff (rst)
    pready && map_w |-> !pslverr) else $error("spurious error");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
    !pready |-> prdata == 32'h0000_0000 && !pslverr) else $error("data outside access");
  a_status_bits: assert property (@(posedge mclk) disable iff (rst)
    pready && !pwrite && paddr == qmc_pkg::OFS_STATUS |-> prdata[31:3] == 29'h0)
    else $error("status upper bits set");
  a_oe_release: assert property (@(posedge mclk) disable iff (rst)
    cs_n |-> quad_data_lines_oe_n == 4'hF) else $error("lines driven while idle");
  a_lane_shape: assert property (@(posedge sclk) disable iff (rst)
    quad_data_lines_oe_n inside {4'hF, 4'hD, 4'h0}) else $error("bad lane enables");
endmodule // qmc_ctrl_checker

// ---- qmc_host.sv ----
// Host SPI controller model, mode 0, 80 ns link clock.
// Assumes the bench calls one task at a time.
module qmc_host (
  output logic            sclk, // Link clock
  output logic            cs_n, // Select
  output logic      [3:0] dq,   // Lines to device
  input  wire logic [3:0] dq_o  // Resolved lines
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq   = 4'h5;
  end
  // Clock stands still between frames
  task automatic tick();
    #40 sclk = 1'b1;
    #40 sclk = 1'b0;
  endtask
  task automatic open_f();
    #17 cs_n = 1'b0;
  endtask
  task automatic close_f();
    #40 cs_n = 1'b1;
    dq = ~dq;
  endtask
  // Released lines toggle so a stale level never reads as data
  task automatic idle(input int n);
    repeat (n) begin
      dq = ~dq;
      tick();
    end
  endtask
  task automatic tx(input logic [7:0] v, input logic q);
    if (q) begin
      dq = v[7:4];
      tick();
      dq = v[3:0];
      tick();
    end else begin
      for (int i = 7; i >= 0; i--) begin
        dq = {~dq[3:1], v[i]};
        tick();
      end
    end
  endtask
  task automatic rx(input logic q, output logic [7:0] v);
    v = 8'h00;
    repeat (q ? 2 : 8) begin
      dq = ~dq;
      #40 v = q ? {v[3:0], dq_o} : {v[6:0], dq_o[1]};
      sclk = 1'b1;
      #40 sclk = 1'b0;
    end
  endtask
endmodule // qmc_host

// ---- quad_mode_entry_exit_control_test.sv ----
// Self-checking bench: APB on mclk, host link model on its own clock.
// Assumes qmc_ctrl, qmc_host and the checker are compiled first.
module quad_mode_entry_exit_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] ap_rd, prdata;
  logic        ap_err, pready, pslverr, sclk, cs_n;
  logic [3:0]  dq_h, dq_o, oe_n, dq_w;
  logic [7:0]  b;
  int          n_fail = 0;
  int          n_tests = 0;
  int          m_qe = 0;
  int          m_cont = 0;
  int          m_four = 0;
  always #5 mclk = ~mclk;
  assign dq_w = (dq_o & ~oe_n) | (dq_h & oe_n);
  qmc_ctrl dut (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .quad_data_lines_i(dq_w),
    .quad_data_lines_o(dq_o), .quad_data_lines_oe_n(oe_n));
  qmc_host host (.sclk(sclk), .cs_n(cs_n), .dq(dq_h), .dq_o(dq_w));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only pready or the watchdog ends this wait
    do @(posedge mclk); while (pready !== 1'b1);
    ap_rd   = prdata;
    ap_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_stat();
    repeat (8) @(posedge mclk);
    apb(1'b0, qmc_pkg::OFS_STATUS, 32'h0000_0000);
    `CHK(ap_rd, 32'(m_qe | m_cont << 1 | m_four << 2))
  endtask
  task automatic op(input logic [7:0] c);
    host.open_f();
    host.tx(c, m_four[0]);
    host.close_f();
  endtask
  task automatic rd_reg(input logic [7:0] c, input logic [7:0] e);
    host.open_f();
    host.tx(c, m_four[0]);
    host.rx(m_four[0], b);
    host.close_f();
    `CHK(b, e)
  endtask
  task automatic wr_sr(input logic [7:0] s2);
    host.open_f();
    host.tx(qmc_pkg::CMD_WR_SR, m_four[0]);
    host.tx(8'($urandom), m_four[0]);
    host.tx(s2, m_four[0]);
    host.close_f();
    m_qe = s2[1];
  endtask
  task automatic qio(input logic [7:0] md);
    logic ok;
    ok = m_cont != 0 || m_qe != 0 || m_four != 0;
    host.open_f();
    if (m_cont == 0) host.tx(qmc_pkg::CMD_RD_QIO, m_four[0]);
    repeat (3) host.tx(8'h00, 1'b1);
    host.tx(md, 1'b1);
    host.idle(4);
    host.rx(1'b1, b);
    host.close_f();
    if (ok) begin
      `CHK(b, 8'hFF)
      m_cont = md[7:4] == 4'hA;
    end
  endtask
  task automatic disc();
    logic [7:0] e;
    host.open_f();
    host.tx(qmc_pkg::CMD_RD_DISC, 1'b0);
    host.tx(8'h00, 1'b0);
    host.tx(8'h00, 1'b0);
    host.tx(8'h36, 1'b0);
    host.idle(8);
    for (int a = 8'h36; a < 8'h3D; a++) begin
      host.rx(1'b0, b);
      e = a == 8'h38 ? 8'h22 : a == 8'h39 ? 8'hF6 : a == 8'h3A ? 8'h5D : 8'hFF;
      `CHK(b, e)
      if (a == 8'h3A) `CHK(b[7], 1'b0)
    end
    host.close_f();
  endtask
  initial begin
    #200_000;
    n_fail++;
    conclude();
  end
  initial begin
    void'($urandom(32'h28fb0b0a));
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    chk_stat();
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK(ap_err, 1'b1)
    apb(1'b1, qmc_pkg::OFS_CTRL, 32'($urandom) | 32'h0000_0001);
    apb(1'b0, qmc_pkg::OFS_CTRL, 32'h0000_0000);
    `CHK(ap_rd[0], 1'b1)
    $display("test registers done");
    rd_reg(qmc_pkg::CMD_RD_SR1, 8'h01);
    apb(1'b1, qmc_pkg::OFS_CTRL, 32'h0000_0000);
    rd_reg(qmc_pkg::CMD_RD_SR1, 8'h00);
    qio(8'hA5);
    chk_stat();
    rd_reg(qmc_pkg::CMD_RD_SR2, 8'h00);
    wr_sr(8'h02);
    rd_reg(qmc_pkg::CMD_RD_SR2, 8'h02);
    disc();
    $display("test status done");
    qio(8'hA5);
    chk_stat();
    qio({4'hA, 4'($urandom)});
    chk_stat();
    qio(8'h00);
    chk_stat();
    qio(8'hA5);
    cont_rst_blk: begin
      host.open_f();
      repeat (4) host.tx(8'hFF, 1'b1);
      host.idle(6);
      `CHK(oe_n, 4'hF)
      host.close_f();
      m_cont = 0;
    end
    chk_stat();
    rd_reg(qmc_pkg::CMD_RD_SR1, 8'h00);
    $display("test continuous done");
    op(qmc_pkg::CMD_QUAD_ON);
    m_four = 1;
    chk_stat();
    rd_reg(qmc_pkg::CMD_RD_SR2, 8'h02);
    wr_sr(8'h00);
    rd_reg(qmc_pkg::CMD_RD_SR2, 8'h00);
    op(qmc_pkg::CMD_QUAD_OFF);
    m_four = 0;
    chk_stat();
    rd_reg(qmc_pkg::CMD_RD_SR1, 8'h00);
    $display("test four lane done");
    conclude();
  end
endmodule // quad_mode_entry_exit_control_test
bind qmc_ctrl qmc_ctrl_checker chk (.mclk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
  .pready, .prdata, .pslverr, .sclk, .cs_n, .quad_data_lines_oe_n);
